// ==== fmc_master.sv ====
// Purpose: Master-side cyclic and service data framer for a slave chain
// Assumes: Link pins are synchronous words; one clock, CE freezes all
// Notes: Frame carries WORDS_PER_SLAVE words per slave through the chain
// Functional notes
// - Once each task period the master sends output data to every slave and collects input data back.
// - Service transfers run only while a request waits, between cyclic frames.
// - The link starts in Init, climbs to Operational, and cyclic control runs only there.
// - A missed frame or service return in Operational drops back to Init until reconnect is asked.
// - One frame passes all slaves in order and returns through them to the master.
// - Output words go master to slave, input words come slave to master.
`timescale 1ns/100ps
module fmc_master #(
    parameter int CYCLE_CNT = fmc_pkg::CYCLE_CNT_DEF,
    parameter int NSLV = fmc_pkg::MAX_SLAVES
) (
    // Clock, reset and enable
    input wire logic CLK_I,
    input wire logic RESET_I,
    input wire logic CE_I,
    // Control
    input wire logic START_I,
    input wire logic RECONNECT_I,
    output logic [1:0] COMM_STATE_O,
    output logic COMM_ERR_O,
    // Output process data source
    input wire logic [fmc_pkg::WORD_W-1:0] OUT_DATA_I,
    output logic OUT_REQ_O,
    // Input process data sink
    output logic IN_VALID_O,
    input wire logic IN_READY_I,
    output logic [fmc_pkg::WORD_W-1:0] IN_DATA_O,
    output logic CYCLE_DONE_O,
    // Service request
    input wire logic SVC_REQ_I,
    input wire logic [1:0] SVC_KIND_I,
    input wire logic [fmc_pkg::SLV_W-1:0] SVC_SLAVE_I,
    input wire logic [fmc_pkg::WORD_W-1:0] SVC_WDATA_I,
    output logic SVC_BUSY_O,
    output logic SVC_DONE_O,
    output logic [fmc_pkg::WORD_W-1:0] SVC_RDATA_O,
    // Link to chain
    output logic TX_VALID_O,
    output logic TX_SOF_O,
    output logic TX_SVC_O,
    output logic [fmc_pkg::WORD_W-1:0] TX_DATA_O,
    input wire logic RX_VALID_I,
    input wire logic [fmc_pkg::WORD_W-1:0] RX_DATA_I
);
    localparam int FW = NSLV * fmc_pkg::WORDS_PER_SLAVE;
    localparam int TW = $clog2(CYCLE_CNT + 1);
    localparam int IW = $clog2(FW + 1);

    fmc_pkg::fmc_comm_t st, next_st;
    fmc_pkg::fmc_phase_t ph, next_ph;
    logic [TW-1:0] tmr, next_tmr;
    logic [IW-1:0] tx_idx, next_tx_idx, rx_idx, next_rx_idx;
    logic err, next_err;
    logic svc_pend, next_svc_pend;
    logic [1:0] svc_kind, next_svc_kind;
    logic [fmc_pkg::SLV_W-1:0] svc_slv, next_svc_slv;
    logic [fmc_pkg::WORD_W-1:0] svc_wd, next_svc_wd;
    logic [fmc_pkg::WORD_W-1:0] svc_rd, next_svc_rd;
    logic svc_done, next_svc_done, cyc_done, next_cyc_done;
    logic tx_v, next_tx_v, tx_sof, next_tx_sof, tx_svc, next_tx_svc;
    logic [fmc_pkg::WORD_W-1:0] tx_d, next_tx_d;
    logic buf_ready, tick, rx_last, frame_ok;
    logic buf_in_v;

    assign tick = (tmr == TW'(CYCLE_CNT - 1));
    assign rx_last = RX_VALID_I && (rx_idx == IW'(FW - 1));
    // Input words only land in the buffer on a cyclic frame
    assign buf_in_v = RX_VALID_I && (ph == fmc_pkg::PH_WAIT);

    // Communication state, frame phase and indices
    always_comb begin
        next_st = st;
        next_ph = ph;
        next_tmr = tick ? '0 : tmr + TW'(1);
        next_tx_idx = tx_idx;
        next_rx_idx = rx_idx;
        next_err = err;
        next_svc_pend = svc_pend;
        next_svc_kind = svc_kind;
        next_svc_slv = svc_slv;
        next_svc_wd = svc_wd;
        next_svc_rd = svc_rd;
        next_svc_done = 1'b0;
        next_cyc_done = 1'b0;
        next_tx_v = 1'b0;
        next_tx_sof = 1'b0;
        next_tx_svc = 1'b0;
        next_tx_d = tx_d;
        frame_ok = 1'b0;
        // Latch a request; it waits for a gap between frames
        if (SVC_REQ_I && !svc_pend) begin
            next_svc_pend = 1'b1;
            next_svc_kind = SVC_KIND_I;
            next_svc_slv = SVC_SLAVE_I;
            next_svc_wd = SVC_WDATA_I;
        end
        unique case (st)
            fmc_pkg::ST_INIT: begin
                next_ph = fmc_pkg::PH_IDLE;
                if (RECONNECT_I || (START_I && !err)) begin
                    next_st = fmc_pkg::ST_PREOP;
                    next_err = 1'b0;
                end
            end
            fmc_pkg::ST_PREOP: begin
                if (tick) begin
                    next_st = fmc_pkg::ST_OP;
                end
            end
            fmc_pkg::ST_OP: begin
                unique case (ph)
                    fmc_pkg::PH_IDLE: begin
                        if (tick) begin
                            next_ph = fmc_pkg::PH_SEND;
                            next_tx_idx = '0;
                            next_rx_idx = '0;
                        end else if (svc_pend) begin
                            next_ph = fmc_pkg::PH_SVC;
                            next_tx_v = 1'b1;
                            next_tx_svc = 1'b1;
                            next_tx_sof = 1'b1;
                            next_tx_d = {svc_kind, 8'h00, svc_slv};
                            next_rx_idx = '0;
                            // Index is left at FW by a cyclic frame
                            next_tx_idx = '0;
                        end
                    end
                    fmc_pkg::PH_SEND: begin
                        // One frame word per clock, WORDS_PER_SLAVE words per slave, in chain order
                        next_tx_v = 1'b1;
                        next_tx_sof = (tx_idx == '0);
                        next_tx_d = OUT_DATA_I;
                        next_tx_idx = tx_idx + IW'(1);
                        if (tx_idx == IW'(FW - 1)) begin
                            next_ph = fmc_pkg::PH_WAIT;
                        end
                    end
                    fmc_pkg::PH_WAIT: begin
                        if (RX_VALID_I) begin
                            next_rx_idx = rx_idx + IW'(1);
                        end
                        if (rx_last) begin
                            next_ph = fmc_pkg::PH_IDLE;
                            next_cyc_done = 1'b1;
                            frame_ok = 1'b1;
                        end
                    end
                    fmc_pkg::PH_SVC: begin
                        next_tx_v = (tx_idx == '0);
                        next_tx_svc = next_tx_v;
                        next_tx_d = svc_wd;
                        next_tx_idx = IW'(1);
                        if (RX_VALID_I) begin
                            next_svc_rd = RX_DATA_I;
                            next_svc_done = 1'b1;
                            next_svc_pend = 1'b0;
                            next_ph = fmc_pkg::PH_IDLE;
                        end
                    end
                endcase
                // Missing return before the next period start
                if (tick && (ph == fmc_pkg::PH_WAIT || ph == fmc_pkg::PH_SEND
                        || ph == fmc_pkg::PH_SVC) && !frame_ok) begin
                    next_err = 1'b1;
                    next_st = fmc_pkg::ST_INIT;
                    next_ph = fmc_pkg::PH_IDLE;
                    // Link goes quiet at once, no word of a cut frame
                    next_tx_v = 1'b0;
                    next_tx_sof = 1'b0;
                    next_tx_svc = 1'b0;
                end
            end
            default: begin
                next_st = fmc_pkg::ST_INIT;
            end
        endcase
        if (ph == fmc_pkg::PH_SVC && next_ph != fmc_pkg::PH_SVC) begin
            next_tx_idx = '0;
        end
    end

    always_ff @(posedge CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            st <= fmc_pkg::ST_INIT;
            ph <= fmc_pkg::PH_IDLE;
            tmr <= '0;
            tx_idx <= '0;
            rx_idx <= '0;
            err <= 1'b0;
            svc_pend <= 1'b0;
            svc_kind <= 2'h0;
            svc_slv <= '0;
            svc_wd <= '0;
            svc_rd <= '0;
            svc_done <= 1'b0;
            cyc_done <= 1'b0;
            tx_v <= 1'b0;
            tx_sof <= 1'b0;
            tx_svc <= 1'b0;
            tx_d <= '0;
        end else if (CE_I) begin
            st <= next_st;
            ph <= next_ph;
            tmr <= next_tmr;
            tx_idx <= next_tx_idx;
            rx_idx <= next_rx_idx;
            err <= next_err;
            svc_pend <= next_svc_pend;
            svc_kind <= next_svc_kind;
            svc_slv <= next_svc_slv;
            svc_wd <= next_svc_wd;
            svc_rd <= next_svc_rd;
            svc_done <= next_svc_done;
            cyc_done <= next_cyc_done;
            tx_v <= next_tx_v;
            tx_sof <= next_tx_sof;
            tx_svc <= next_tx_svc;
            tx_d <= next_tx_d;
        end
    end

    // Returned input words, buffered so a one-cycle stall of the sink loses nothing
    fmc_buf2 #(
        .W(fmc_pkg::WORD_W)
    ) u_inbuf (
        .clk_i(CLK_I),
        .reset_i(RESET_I),
        .ce_i(CE_I),
        .in_valid_i(buf_in_v),
        .in_ready_o(buf_ready),
        .in_data_i(RX_DATA_I),
        .out_valid_o(IN_VALID_O),
        .out_ready_i(IN_READY_I),
        .out_data_o(IN_DATA_O)
    );

    // Outputs; a word arriving at a full buffer with the sink stalled is an overrun, seen as error
    assign COMM_STATE_O = st;
    assign COMM_ERR_O = err || (buf_in_v && !buf_ready);
    assign OUT_REQ_O = (st == fmc_pkg::ST_OP) && (ph == fmc_pkg::PH_SEND);
    assign CYCLE_DONE_O = cyc_done;
    assign SVC_BUSY_O = svc_pend;
    assign SVC_DONE_O = svc_done;
    assign SVC_RDATA_O = svc_rd;
    assign TX_VALID_O = tx_v;
    assign TX_SOF_O = tx_sof;
    assign TX_SVC_O = tx_svc;
    assign TX_DATA_O = tx_d;

    // Frame opening: a period start in Op, then the first slot word
    sequence frame_start_s;
        st == fmc_pkg::ST_OP && ph == fmc_pkg::PH_IDLE && tick && CE_I;
    endsequence
    sequence first_word_s;
        tx_v && tx_sof && !tx_svc;
    endsequence

    op_only_a: assert property (@(posedge CLK_I)
        disable iff (RESET_I)
        (tx_v && !tx_svc) |-> st == fmc_pkg::ST_OP)
        else $error("cyclic word outside operational");
    timeout_a: assert property (@(posedge CLK_I)
        disable iff (RESET_I)
        (CE_I && tick && st == fmc_pkg::ST_OP && ph == fmc_pkg::PH_WAIT
         && !rx_last) |=> st == fmc_pkg::ST_INIT && err)
        else $error("timeout did not drop to init");
    init_hold_a: assert property (@(posedge CLK_I)
        disable iff (RESET_I)
        (st == fmc_pkg::ST_INIT && !START_I && !RECONNECT_I)
        |=> st == fmc_pkg::ST_INIT)
        else $error("left init without request");
    cycle_send_a: assert property (@(posedge CLK_I)
        disable iff (RESET_I)
        frame_start_s |=> ph == fmc_pkg::PH_SEND)
        else $error("period start did not begin frame");
    svc_idle_a: assert property (@(posedge CLK_I)
        disable iff (RESET_I)
        (tx_svc && tx_v) |-> svc_pend)
        else $error("service word without request");
    frame_order_a: assert property (@(posedge CLK_I)
        disable iff (RESET_I)
        (CE_I && ph == fmc_pkg::PH_SEND && tx_idx == '0 && !tick)
        |=> first_word_s)
        else $error("frame did not open with first slot");
    in_dir_a: assert property (@(posedge CLK_I)
        disable iff (RESET_I)
        (CE_I && buf_in_v && buf_ready && !IN_VALID_O)
        |=> IN_VALID_O && IN_DATA_O == $past(RX_DATA_I))
        else $error("returned word did not reach the sink");
    done_pulse_a: assert property (@(posedge CLK_I)
        disable iff (RESET_I)
        (CE_I && svc_done) |=> !svc_done)
        else $error("service done longer than a pulse");
endmodule // fmc_master

// ==== fmc_pkg.sv ====
// Purpose: Shared constants for the fieldbus master cycle framer
// Assumes: 250 MHz system clock
// Notes: Times are kept in their own unit, cycle counts derived here
package fmc_pkg;
    localparam int CLK_MHZ = 250;
    localparam int CYCLE_US_DEF = 1000;     // Main task period, us (1/2/4 ms)
    localparam int CYCLE_CNT_DEF = CYCLE_US_DEF * CLK_MHZ;
    localparam int MAX_SLAVES = 36;
    localparam int WORD_W = 16;
    localparam int WORDS_PER_SLAVE = 4;
    localparam int SLV_W = 6;
    // Service request kinds
    localparam logic [1:0] SVC_RD_PARAM = 2'h0;
    localparam logic [1:0] SVC_WR_PARAM = 2'h1;
    localparam logic [1:0] SVC_RD_ERROR = 2'h2;
    // Communication states
    typedef enum logic [1:0] {
        ST_INIT = 2'b00,
        ST_PREOP = 2'b01,
        ST_OP = 2'b10
    } fmc_comm_t;
    // Frame phases
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_SEND = 2'b01,
        PH_WAIT = 2'b10,
        PH_SVC = 2'b11
    } fmc_phase_t;
endpackage

// ==== fmc_buf2.sv ====
// Purpose: Two-entry buffer with valid/ready on both sides
// Assumes: Single clock, synchronous enable
// Notes: Full throughput; a pop frees a full slot within the same cycle
`timescale 1ns/100ps
module fmc_buf2 #(
    parameter int W = 16
) (
    // Clock, reset and enable
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Write side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    // Read side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    logic [W-1:0] mem [2];
    logic [1:0] cnt;
    logic rd, wr;
    logic [1:0] next_cnt;
    logic next_rd, next_wr;

    // Full but draining still takes a word: the writer cannot stall, so
    // a one-cycle stall of the reader must not drop the next word
    assign in_ready_o = (cnt != 2'h2) || out_ready_i;
    assign out_valid_o = (cnt != 2'h0);
    assign out_data_o = mem[rd];

    // Occupancy and pointers
    always_comb begin
        logic push, pop;
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        next_cnt = cnt + {1'b0, push} - {1'b0, pop};
        next_wr = push ? ~wr : wr;
        next_rd = pop ? ~rd : rd;
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt <= 2'h0;
            rd <= 1'b0;
            wr <= 1'b0;
        end else if (ce_i) begin
            cnt <= next_cnt;
            rd <= next_rd;
            wr <= next_wr;
        end
    end

    // Storage carries no reset; only valid entries are ever read
    always_ff @(posedge clk_i) begin
        if (ce_i && in_valid_i && in_ready_o) begin
            mem[wr] <= in_data_i;
        end
    end

    occ_bound_a: assert property (@(posedge clk_i) disable iff (reset_i)
        cnt <= 2'h2) else $error("buffer count over two");
endmodule // fmc_buf2

// ==== fmc_chain_model.sv ====
// Purpose: Behavioural chain of slaves facing the cycle framer
// Assumes: One word a clock; mode 0 prompt, 1 slow, 2 silent
// Notes: Idle return line inverts its last value every clock
`timescale 1ns/100ps
module fmc_chain_model (
    // Clock
    input wire logic clk_i,
    // Words from the master, and the bench's response mode
    input wire logic tx_valid_i,
    input wire logic tx_sof_i,
    input wire logic tx_svc_i,
    input wire logic [15:0] tx_data_i,
    input wire logic [1:0] mode_i,
    // Words back to the master
    output logic rx_valid_o,
    output logic [15:0] rx_data_o
);
    logic [15:0] q[$];
    int dly = 0;
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o = 16'h0000;
    end
    // Each slave patches its input area as the frame passes
    always @(posedge clk_i) begin
        if (tx_valid_i === 1'b1 && mode_i != 2'h2) begin
            if (tx_svc_i !== 1'b1)
                q.push_back(tx_data_i ^ 16'h0f0f);
            else if (tx_sof_i !== 1'b1)
                q.push_back(~tx_data_i);
        end
    end
    // Frame turns at the last slave once it has fully passed; slow mode
    // models a long chain
    always @(negedge clk_i) begin
        if (tx_valid_i !== 1'b1 && q.size() > 0
                && dly >= (mode_i == 2'h1 ? 20 : 2)) begin
            rx_valid_o <= 1'b1;
            rx_data_o <= q.pop_front();
        end else begin
            if (q.size() > 0 && tx_valid_i !== 1'b1)
                dly++;
            else
                dly = 0;
            rx_valid_o <= 1'b0;
            rx_data_o <= ~rx_data_o; // Quiet line inverts every bit each clock
        end
    end
endmodule // fmc_chain_model

// ==== fieldbus_master_cycle_test.sv ====
// Purpose: Self-checking bench for the fieldbus master cycle framer
// Assumes: Short period and two slaves keep the run brief
// Notes: Inputs change at the falling edge only
`timescale 1ns/100ps
module fieldbus_master_cycle_test;
    localparam int CYC = 200;
    logic CLK_I = 1'b0, RESET_I = 1'b1, CE_I = 1'b1;
    logic START_I = 1'b0, RECONNECT_I = 1'b0, IN_READY_I = 1'b1;
    logic SVC_REQ_I = 1'b0, COMM_ERR_O, OUT_REQ_O, IN_VALID_O;
    logic CYCLE_DONE_O, SVC_BUSY_O, SVC_DONE_O, TX_VALID_O, TX_SOF_O;
    logic TX_SVC_O, RX_VALID_I;
    logic [1:0] COMM_STATE_O, SVC_KIND_I = 2'h0, mode = 2'h0;
    logic [5:0] SVC_SLAVE_I = 6'h00;
    logic [15:0] OUT_DATA_I = 16'h0000, SVC_WDATA_I = 16'h0000;
    logic [15:0] IN_DATA_O, SVC_RDATA_O, TX_DATA_O, RX_DATA_I;
    logic [7:0] slot = 8'h00, fr = 8'h00;
    logic [15:0] txq[$], svq[$], inq[$];
    int n_mismatch = 0, comparisons = 0, cyc = 0, n_tx = 0;
    int t_done = 0, t1 = 0, k;

    fmc_master #(.CYCLE_CNT(CYC), .NSLV(2)) i_dut (.CLK_I(CLK_I),
        .RESET_I(RESET_I), .CE_I(CE_I), .START_I(START_I),
        .RECONNECT_I(RECONNECT_I), .COMM_STATE_O(COMM_STATE_O),
        .COMM_ERR_O(COMM_ERR_O), .OUT_DATA_I(OUT_DATA_I),
        .OUT_REQ_O(OUT_REQ_O), .IN_VALID_O(IN_VALID_O),
        .IN_READY_I(IN_READY_I), .IN_DATA_O(IN_DATA_O),
        .CYCLE_DONE_O(CYCLE_DONE_O), .SVC_REQ_I(SVC_REQ_I),
        .SVC_KIND_I(SVC_KIND_I), .SVC_SLAVE_I(SVC_SLAVE_I),
        .SVC_WDATA_I(SVC_WDATA_I), .SVC_BUSY_O(SVC_BUSY_O),
        .SVC_DONE_O(SVC_DONE_O), .SVC_RDATA_O(SVC_RDATA_O),
        .TX_VALID_O(TX_VALID_O), .TX_SOF_O(TX_SOF_O), .TX_SVC_O(TX_SVC_O),
        .TX_DATA_O(TX_DATA_O), .RX_VALID_I(RX_VALID_I),
        .RX_DATA_I(RX_DATA_I));
    fmc_chain_model i_chain (.clk_i(CLK_I), .tx_valid_i(TX_VALID_O),
        .tx_sof_i(TX_SOF_O), .tx_svc_i(TX_SVC_O), .tx_data_i(TX_DATA_O),
        .mode_i(mode), .rx_valid_o(RX_VALID_I), .rx_data_o(RX_DATA_I));

    // 250 MHz clock
    always #2 CLK_I = ~CLK_I;
    // Hang guard, well above the few thousand cycles needed
    always @(posedge CLK_I) begin
        cyc++;
        if (cyc == 8000) begin
            $display("BAD %0t run hung", $time);
            n_mismatch++;
            close_out();
        end
    end
    // Record link and sink traffic; a start of frame opens a new record
    always @(posedge CLK_I) begin
        slot <= (OUT_REQ_O === 1'b1) ? slot + 8'h01 : 8'h00;
        if (TX_VALID_O === 1'b1)
            n_tx++;
        if (TX_VALID_O === 1'b1 && TX_SVC_O === 1'b1)
            svq.push_back(TX_DATA_O);
        if (TX_VALID_O === 1'b1 && TX_SVC_O !== 1'b1) begin
            if (TX_SOF_O === 1'b1) begin
                txq = {};
                inq = {};
            end
            txq.push_back(TX_DATA_O);
        end
        if (IN_VALID_O === 1'b1 && IN_READY_I === 1'b1)
            inq.push_back(IN_DATA_O);
    end
    // Output word tags frame number and slot
    always @(negedge CLK_I) OUT_DATA_I <= {fr, slot};

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Quiet until started, then PreOp, then Op on a period tick
    task automatic bring_up();
        int i;
        int n0;
        n0 = n_tx;
        chk16({14'h0, COMM_STATE_O}, 16'h0000, "reset state");
        repeat (2 * CYC + 50) @(negedge CLK_I);
        chk16({14'h0, COMM_STATE_O}, 16'h0000, "waits start");
        START_I = 1'b1;
        @(negedge CLK_I);
        START_I = 1'b0;
        chk16({14'h0, COMM_STATE_O}, 16'h0001, "preop");
        for (i = 0; i < 450 && COMM_STATE_O !== 2'h2; i++)
            @(negedge CLK_I);
        chk16({14'h0, COMM_STATE_O}, 16'h0002, "op");
        chk16(16'(n_tx - n0), 16'h0000, "no traffic before op");
    endtask

    // One cyclic frame; optional one-cycle stall of the sink
    task automatic frame(input logic [1:0] md, input bit stall);
        int i;
        bit st;
        st = 1'b0;
        mode = md;
        fr++;
        for (i = 0; i < 600 && CYCLE_DONE_O !== 1'b1; i++) begin
            @(negedge CLK_I);
            IN_READY_I = !(stall && !st && inq.size() == 2);
            if (!IN_READY_I)
                st = 1'b1;
        end
        t_done = cyc;
        IN_READY_I = 1'b1;
        repeat (6) @(negedge CLK_I);
        chk16(16'(txq.size()), 16'h0008, "frame words");
        foreach (txq[j])
            chk16(txq[j], {fr, 8'(j)}, "out word");
        chk16(16'(inq.size()), 16'h0008, "returned words");
        foreach (inq[j])
            chk16(inq[j], {fr, 8'(j)} ^ 16'h0f0f, "in word");
        chk16({15'h0, COMM_ERR_O}, 16'h0000, "no error");
    endtask

    // One service transfer to slave 1
    task automatic svc(input logic [1:0] kind);
        int i;
        svq = {};
        SVC_KIND_I = kind;
        SVC_SLAVE_I = 6'h01;
        SVC_WDATA_I = {8'h5a, 6'h00, kind};
        SVC_REQ_I = 1'b1;
        @(negedge CLK_I);
        SVC_REQ_I = 1'b0;
        chk16({15'h0, SVC_BUSY_O}, 16'h0001, "busy");
        for (i = 0; i < 600 && SVC_DONE_O !== 1'b1; i++)
            @(negedge CLK_I);
        chk16({15'h0, SVC_BUSY_O}, 16'h0000, "not busy");
        chk16(SVC_RDATA_O, ~{8'h5a, 6'h00, kind}, "answer");
        chk16(16'(svq.size()), 16'h0002, "service words");
        chk16(svq[0], {kind, 8'h00, 6'h01}, "header");
    endtask

    // Enable low: nothing moves, so the period stretches by the frozen time
    task automatic freeze_hold();
        int n0;
        n0 = n_tx;
        t1 = t_done;
        CE_I = 1'b0;
        repeat (300) @(negedge CLK_I);
        chk16(16'(n_tx - n0), 16'h0000, "frozen link");
        chk16({14'h0, COMM_STATE_O}, 16'h0002, "frozen state");
        CE_I = 1'b1;
        frame(2'h0, 1'b0);
        chk16(16'(t_done - t1), 16'h01f4, "stretched period");
    endtask

    // Silent chain: error, Init, deaf to start, back on reconnect
    task automatic lose_link();
        int i;
        int n0;
        mode = 2'h2;
        for (i = 0; i < 600 && COMM_ERR_O !== 1'b1; i++)
            @(negedge CLK_I);
        chk16({15'h0, COMM_ERR_O}, 16'h0001, "late frame");
        @(negedge CLK_I);
        chk16({14'h0, COMM_STATE_O}, 16'h0000, "dropped");
        mode = 2'h0;
        n0 = n_tx;
        SVC_KIND_I = 2'h2;
        SVC_WDATA_I = 16'h0000;
        SVC_REQ_I = 1'b1;
        START_I = 1'b1;
        @(negedge CLK_I);
        SVC_REQ_I = 1'b0;
        START_I = 1'b0;
        repeat (2 * CYC + 50) @(negedge CLK_I);
        chk16(16'(n_tx - n0), 16'h0000, "link stopped");
        chk16({14'h0, COMM_STATE_O}, 16'h0000, "start refused");
        RECONNECT_I = 1'b1;
        @(negedge CLK_I);
        RECONNECT_I = 1'b0;
        for (i = 0; i < 600 && SVC_DONE_O !== 1'b1; i++)
            @(negedge CLK_I);
        chk16({14'h0, COMM_STATE_O}, 16'h0002, "reconnected");
        chk16(SVC_RDATA_O, 16'hffff, "held service");
        frame(2'h0, 1'b0);
    endtask

    // Main sequence
    initial begin
        repeat (8) @(negedge CLK_I);
        RESET_I = 1'b0;
        chk16({15'h0, TX_VALID_O}, 16'h0000, "tx idle");
        bring_up();
        frame(2'h0, 1'b0);
        t1 = t_done;
        frame(2'h0, 1'b1);
        chk16(16'(t_done - t1), 16'h00c8, "frame spacing");
        freeze_hold();
        frame(2'h1, 1'b0);
        for (k = 0; k < 3; k++)
            svc(2'(k));
        lose_link();
        close_out();
    end
endmodule // fieldbus_master_cycle_test
